// *** indexed_port_watchdog_timer.sv ***
// Purpose: watchdog reached through an index/data i/o port pair
// Assumes: one host access per strobe cycle, strobes synchronous
// Notes: the timeout action strap is caught once after reset release
`timescale 1ns/1ns
//
// Contract
// - decode index port and next data port
// - two unlock keys open configuration access
// - device select 08 routes to watchdog set
// - activation 01 enables; disabled after reset
// - unit bit 3: seconds default, minutes
// - count zero stops; 1 to 255 counts
// - elapsed count raises interrupt or reset
// - count write reloads and restarts timer
// - control bit 6 lets keyboard reload
// - control bit 5 forces timeout, self-clears
// - control bit 4 reads timeout status
// - lock key ends configuration access
// - interrupt active low until timer reset
// - strap picks system reset or interrupt
module indexed_port_watchdog_timer #(
    parameter int SEC_CYCLES = wdt_pkg::SEC_CYCLES,
    parameter int MIN_UNITS = wdt_pkg::MIN_UNITS
) (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire wdt_pkg::io_req_type IO_REQ_I,
    output logic [7:0] IO_RDATA_O,
    output logic IO_RVALID_O,
    input wire logic KBD_ACT_I,
    input wire logic TIMEOUT_ACTION_STRAP_I,
    output logic WDT_IRQ_N_O,
    output logic SYS_RST_O
);
    import wdt_pkg::*;

    // register hit on the current index
    function automatic logic idx_is(input logic [7:0] idx,
                                    input logic [7:0] target);
        idx_is = idx == target;
    endfunction

    key_state_type key_state_reg;
    key_state_type key_state_next;
    logic [7:0] index_reg;
    logic [7:0] index_next;
    logic [7:0] ldn_reg;
    logic [7:0] ldn_next;
    logic act_reg;
    logic act_next;
    logic [7:0] unit_reg;
    logic [7:0] unit_next;
    logic [7:0] count_cfg_reg;
    logic [7:0] count_cfg_next;
    logic kbd_en_reg;
    logic kbd_en_next;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic timeout_reg;
    logic timeout_next;
    logic strap_reg;
    logic strap_seen_reg;
    logic irq_n_reg;
    logic sys_rst_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic tick;

    // port decode
    wire idx_port = IO_REQ_I.addr == INDEX_PORT;
    wire dat_port = IO_REQ_I.addr == DATA_PORT;
    wire idx_wr = IO_REQ_I.wr & idx_port;
    wire dat_wr = IO_REQ_I.wr & dat_port;
    wire dat_rd = IO_REQ_I.rd & dat_port;
    wire any_rd = IO_REQ_I.rd & (idx_port | dat_port);
    wire [7:0] wd = IO_REQ_I.data;
    wire is_open = key_state_reg == KEY_OPEN;

    // data writes land only when open; watchdog set only on its ldn
    wire cfg_wr = dat_wr & is_open;
    wire wdt_sel = ldn_reg == LDN_WDT;
    wire wdt_wr = cfg_wr & wdt_sel;
    wire ldn_wr = cfg_wr & idx_is(index_reg, REG_LDN);
    wire act_wr = wdt_wr & idx_is(index_reg, REG_ACT);
    wire unit_wr = wdt_wr & idx_is(index_reg, REG_UNIT);
    wire count_wr = wdt_wr & idx_is(index_reg, REG_COUNT);
    wire ctrl_wr = wdt_wr & idx_is(index_reg, REG_CTRL);

    // key sequencer: any other index write breaks a half-entered key
    always_comb begin
        key_state_next = key_state_reg;
        if (idx_wr) begin
            case (key_state_reg)
                KEY_LOCKED: begin
                    if (wd == UNLOCK_KEY) begin
                        key_state_next = KEY_HALF;
                    end
                end
                KEY_HALF: begin
                    if (wd == UNLOCK_KEY) begin
                        key_state_next = KEY_OPEN;
                    end else begin
                        key_state_next = KEY_LOCKED;
                    end
                end
                KEY_OPEN: begin
                    if (wd == LOCK_KEY) begin
                        key_state_next = KEY_LOCKED;
                    end
                end
                default: begin
                    key_state_next = KEY_LOCKED;
                end
            endcase
        end
    end

    // index latch; the lock key is not taken as an index
    assign index_next = (idx_wr & is_open & (wd != LOCK_KEY)) ?
        wd : index_reg;

    // configuration register updates
    assign ldn_next = ldn_wr ? wd : ldn_reg;
    assign act_next = act_wr ? wd[ACT_ON_BIT] : act_reg;
    assign unit_next = unit_wr ? wd : unit_reg;
    assign count_cfg_next = count_wr ? wd : count_cfg_reg;
    assign kbd_en_next = ctrl_wr ? wd[KBD_EN_BIT] : kbd_en_reg;

    // countdown control
    wire running = act_reg & (count_cfg_reg != 8'h00) & ~timeout_reg;
    wire kbd_reload = kbd_en_reg & KBD_ACT_I;
    wire reload = count_wr | kbd_reload;
    wire force_to = ctrl_wr & wd[FORCE_BIT];
    wire expire = running & tick & (cnt_reg == 8'h01) & ~reload;

    assign cnt_next = count_wr ? wd :
        kbd_reload ? count_cfg_reg :
        (running & tick) ? cnt_reg - 8'h01 : cnt_reg;

    // a forced timeout wins over a same-cycle reload; expiry does not
    assign timeout_next = force_to | expire |
        (timeout_reg & ~reload);

    // unit prescaler, realigned on every reload
    unit_tick_gen #(
        .SEC_CYCLES(SEC_CYCLES),
        .MIN_UNITS(MIN_UNITS)
    ) u_tick (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .run_i(running),
        .restart_i(reload),
        .minutes_i(unit_reg[UNIT_MIN_BIT]),
        .tick_o(tick)
    );

    // read mux; bit 5 of control always reads back zero
    always_comb begin
        rdata_next = IDLE_READ;
        if (IO_REQ_I.rd & idx_port & is_open) begin
            rdata_next = index_reg;
        end else if (dat_rd & is_open) begin
            if (idx_is(index_reg, REG_LDN)) begin
                rdata_next = ldn_reg;
            end else if (wdt_sel) begin
                case (index_reg)
                    REG_ACT: rdata_next = {7'h00, act_reg};
                    REG_UNIT: rdata_next = unit_reg;
                    REG_COUNT: rdata_next = count_cfg_reg;
                    REG_CTRL: begin
                        rdata_next = IDLE_READ;
                        rdata_next[KBD_EN_BIT] = kbd_en_reg;
                        rdata_next[STATUS_BIT] = timeout_reg;
                    end
                    default: rdata_next = IDLE_READ;
                endcase
            end
        end
    end

    // host-visible state
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            key_state_reg <= KEY_LOCKED;
            index_reg <= RST_INDEX;
            ldn_reg <= RST_LDN;
            act_reg <= RST_ACT[ACT_ON_BIT];
            unit_reg <= RST_UNIT;
            count_cfg_reg <= RST_COUNT;
            kbd_en_reg <= RST_CTRL[KBD_EN_BIT];
            rdata_reg <= IDLE_READ;
            rvalid_reg <= 1'b0;
        end else begin
            key_state_reg <= key_state_next;
            index_reg <= index_next;
            ldn_reg <= ldn_next;
            act_reg <= act_next;
            unit_reg <= unit_next;
            count_cfg_reg <= count_cfg_next;
            kbd_en_reg <= kbd_en_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= any_rd;
        end
    end

    // timer state and pin drivers
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_reg <= RST_COUNT;
            timeout_reg <= 1'b0;
            irq_n_reg <= 1'b1;
            sys_rst_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            timeout_reg <= timeout_next;
            irq_n_reg <= ~(timeout_reg & ~strap_reg);
            sys_rst_reg <= timeout_reg & strap_reg;
        end
    end

    // strap caught on the first edge after release, not at reset
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            strap_reg <= 1'b0;
            strap_seen_reg <= 1'b0;
        end else if (!strap_seen_reg) begin
            strap_reg <= TIMEOUT_ACTION_STRAP_I;
            strap_seen_reg <= 1'b1;
        end
    end

    assign IO_RDATA_O = rdata_reg;
    assign IO_RVALID_O = rvalid_reg;
    assign WDT_IRQ_N_O = irq_n_reg;
    assign SYS_RST_O = sys_rst_reg;

    // checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);

    a_index_latch: assert property (
        idx_wr && is_open && wd != LOCK_KEY |=> index_reg == $past(wd))
        else $error("index port write not latched");

    a_unlock_pair: assert property (
        key_state_reg == KEY_HALF && idx_wr && wd == UNLOCK_KEY
        |=> key_state_reg == KEY_OPEN)
        else $error("second unlock key did not open access");

    a_lock_key: assert property (
        is_open && idx_wr && wd == LOCK_KEY |=> key_state_reg == KEY_LOCKED)
        else $error("lock key did not close access");

    a_locked_ignore: assert property (
        !is_open |=> $stable(count_cfg_reg) && $stable(act_reg)
        && $stable(kbd_en_reg) && $stable(ldn_reg))
        else $error("settings changed while locked");

    a_ldn_route: assert property (
        !wdt_sel |=> $stable(count_cfg_reg) && $stable(unit_reg))
        else $error("watchdog set written on another device");

    a_count_reload: assert property (
        count_wr |=> cnt_reg == $past(wd) && !timeout_reg)
        else $error("count write did not reload timer");

    a_stop_idle: assert property (
        (!act_reg || count_cfg_reg == 8'h00) && !reload
        |=> $stable(cnt_reg))
        else $error("timer moved while stopped or disabled");

    a_expire_set: assert property (
        running && tick && cnt_reg == 8'h01 && !reload |=> timeout_reg)
        else $error("expiry did not flag timeout");

    sequence force_seq;
        ctrl_wr && wd[FORCE_BIT];
    endsequence

    sequence pin_seq;
        timeout_reg ##1 (!WDT_IRQ_N_O || SYS_RST_O);
    endsequence

    a_force_timeout: assert property (
        force_seq |=> pin_seq)
        else $error("forced timeout did not reach a pin");

    a_force_selfclr: assert property (
        rvalid_reg && $past(dat_rd && is_open && wdt_sel
        && index_reg == REG_CTRL) |-> !IO_RDATA_O[FORCE_BIT])
        else $error("force bit read back as one");

    a_status_read: assert property (
        dat_rd && is_open && wdt_sel && index_reg == REG_CTRL
        |=> IO_RDATA_O[STATUS_BIT] == $past(timeout_reg))
        else $error("status bit does not show timeout");

    a_kbd_reload: assert property (
        kbd_en_reg && KBD_ACT_I && !count_wr
        |=> cnt_reg == $past(count_cfg_reg))
        else $error("keyboard activity did not reload");

    a_irq_hold: assert property (
        timeout_reg && !strap_reg ##1 timeout_reg |-> !WDT_IRQ_N_O)
        else $error("interrupt released before timer reset");

    a_strap_route: assert property (
        strap_reg |-> WDT_IRQ_N_O)
        else $error("interrupt driven in reset mode");

    a_rvalid_pulse: assert property (
        any_rd |=> IO_RVALID_O)
        else $error("port read not answered");

    a_rvalid_idle: assert property (
        !any_rd |=> !IO_RVALID_O)
        else $error("read answer without a read");

    a_locked_read: assert property (
        IO_REQ_I.rd && dat_port && !is_open |=> IO_RDATA_O == IDLE_READ)
        else $error("locked data read returned settings");

    a_act_enable: assert property (
        act_wr |=> act_reg == $past(wd[ACT_ON_BIT]))
        else $error("activation write not taken");

    a_unit_select: assert property (
        unit_wr |=> unit_reg == $past(wd))
        else $error("unit write not taken");

    a_count_zero: assert property (
        count_cfg_reg == 8'h00 && !reload |=> $stable(cnt_reg) && !tick)
        else $error("timer ran with a zero count");

    a_sysrst_level: assert property (
        timeout_reg && strap_reg |=> SYS_RST_O)
        else $error("timeout did not request a reset");

    a_sysrst_off: assert property (
        !strap_reg |-> !SYS_RST_O)
        else $error("reset requested in interrupt mode");

    a_kbd_off: assert property (
        !kbd_en_reg && !count_wr && !(running && tick) |=> $stable(cnt_reg))
        else $error("timer reloaded with keyboard reload off");

endmodule

// *** indexed_port_watchdog_timer_tb_top.sv ***
// Purpose: self-checking bench for the indexed-port watchdog
// Assumes: short unit counts so each counted expiry takes 40 to 180 cycles
// Notes: a small integer model predicts every control read and pin level
`timescale 1ns/1ns
`define CHECK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module indexed_port_watchdog_timer_tb_top;
    import wdt_pkg::*;
    localparam int SEC = 20;
    localparam int MINU = 3;
    logic clk;
    logic nrst;
    io_req_type io_req;
    logic [7:0] rdata;
    logic rvalid;
    logic kbd;
    logic strap;
    logic irq_n;
    logic sys_rst;
    int errors;
    int tests_run;
    int m_open;
    int m_ldn;
    int m_kbd;
    int m_to;
    int m_strap;
    int cnt;
    int exp_q[$];
    indexed_port_watchdog_timer #(.SEC_CYCLES(SEC), .MIN_UNITS(MINU))
    u_dut (.CLK_I(clk), .NRST_I(nrst), .IO_REQ_I(io_req),
        .IO_RDATA_O(rdata), .IO_RVALID_O(rvalid), .KBD_ACT_I(kbd),
        .TIMEOUT_ACTION_STRAP_I(strap), .WDT_IRQ_N_O(irq_n),
        .SYS_RST_O(sys_rst));
    wdt_host_model u_host (.clk_i(clk), .rdata_i(rdata),
        .rvalid_i(rvalid), .req_o(io_req));
    // free-running core clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // strap is only caught after release, so each strap needs a reset
    task automatic do_reset(input logic s);
        strap <= s;
        nrst <= 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        m_open = 0;
        m_ldn = 0;
        m_kbd = 0;
        m_to = 0;
        m_strap = s;
    endtask
    task automatic chk_pins();
        `CHECK("irq_n", !(m_to && m_strap == 0), irq_n)
        `CHECK("sys_rst", (m_to && m_strap == 1), sys_rst)
    endtask
    // write through the host and mirror it in the model
    task automatic mwr(input logic [7:0] idx, input logic [7:0] v);
        u_host.reg_wr(idx, v);
        if (m_open && idx == REG_LDN) m_ldn = v;
        if (m_open && m_ldn == 8 && idx == REG_COUNT) m_to = 0;
        if (m_open && m_ldn == 8 && idx == REG_CTRL) begin
            m_kbd = v[6];
            if (v[5]) m_to = 1;
        end
    endtask
    // expected control byte queued from the model before the read
    task automatic mrd_ctrl();
        logic [7:0] d;
        logic ok;
        int e;
        exp_q.push_back(m_open ? (m_kbd << 6) | (m_to << 4) : 0);
        u_host.reg_rd(REG_CTRL, d, ok);
        e = exp_q.pop_front();
        `CHECK("ctrl ack", 1'b1, ok)
        `CHECK("ctrl", 8'(e), d)
    endtask
    // count cycles until a pin fires; window allows pipeline slack
    // first edge lets a cleared timeout release the pins first
    task automatic wait_expiry(input int exp);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (irq_n === 1'b1 && sys_rst === 1'b0 && n < exp + 20);
        `CHECK("expiry window", 1'b1, n >= exp && n <= exp + 5)
        m_to = 1;
        chk_pins();
    endtask
    initial begin
        logic [7:0] d;
        logic ok;
        errors = 0;
        tests_run = 0;
        nrst = 1'b0;
        kbd = 1'b0;
        strap = 1'b0;
        void'($urandom(80));
        do_reset(1'b0);
        chk_pins();
        u_host.port_rd(DATA_PORT, d, ok);
        `CHECK("locked ack", 1'b1, ok)
        `CHECK("locked read", 8'h00, d)
        u_host.reg_wr(REG_COUNT, 8'h01);
        u_host.port_wr(16'h0080, UNLOCK_KEY);
        u_host.unlock();
        m_open = 1;
        mwr(REG_LDN, LDN_WDT);
        mwr(REG_ACT, 8'h01);
        repeat (60) @(posedge clk);
        chk_pins();
        $display("test locked_writes done");
        kbd <= 1'b1;
        mwr(REG_UNIT, 8'h00);
        mwr(REG_COUNT, 8'h03);
        wait_expiry(3 * SEC);
        kbd <= 1'b0;
        repeat (30) @(posedge clk);
        chk_pins();
        mrd_ctrl();
        mwr(REG_COUNT, 8'h02);
        repeat (2) @(posedge clk);
        chk_pins();
        repeat (25) @(posedge clk);
        mwr(REG_COUNT, 8'h02);
        wait_expiry(2 * SEC);
        $display("test expiry_reload done");
        mwr(REG_ACT, 8'h00);
        mwr(REG_COUNT, 8'h01);
        repeat (60) @(posedge clk);
        chk_pins();
        mwr(REG_ACT, 8'h01);
        mwr(REG_COUNT, 8'h00);
        repeat (60) @(posedge clk);
        chk_pins();
        $display("test stopped done");
        mwr(REG_CTRL, 8'h40);
        mrd_ctrl();
        mwr(REG_COUNT, 8'h02);
        for (int i = 0; i < 6; i++) begin
            repeat (15) @(posedge clk);
            kbd <= 1'b1;
            @(posedge clk);
            kbd <= 1'b0;
        end
        chk_pins();
        mwr(REG_CTRL, 8'h20);
        repeat (3) @(posedge clk);
        chk_pins();
        mrd_ctrl();
        u_host.port_rd(INDEX_PORT, d, ok);
        `CHECK("index read", REG_CTRL, d)
        $display("test keyboard_force done");
        mwr(REG_CTRL, 8'h00);
        mwr(REG_UNIT, 8'h08);
        cnt = $urandom_range(3, 1);
        mwr(REG_COUNT, 8'(cnt));
        wait_expiry(cnt * SEC * MINU);
        $display("test minutes done");
        mwr(REG_COUNT, 8'h00);
        mwr(REG_LDN, 8'h07);
        mwr(REG_CTRL, 8'h20);
        mwr(REG_LDN, LDN_WDT);
        u_host.lock();
        m_open = 0;
        mwr(REG_CTRL, 8'h20);
        repeat (3) @(posedge clk);
        chk_pins();
        mrd_ctrl();
        $display("test select_lock done");
        do_reset(1'b1);
        u_host.unlock();
        m_open = 1;
        mwr(REG_LDN, LDN_WDT);
        mwr(REG_ACT, 8'h01);
        mwr(REG_CTRL, 8'h20);
        repeat (3) @(posedge clk);
        chk_pins();
        $display("test strap_reset done");
        results();
    end
endmodule

// *** unit_tick_gen.sv ***
// Purpose: one-cycle tick per second or per minute
// Assumes: restart_i realigns the unit boundary to the reload
// Notes: counts stop and clear while run_i is low
`timescale 1ns/1ns
module unit_tick_gen #(
    parameter int SEC_CYCLES = 125000000,
    parameter int MIN_UNITS = 60
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic minutes_i,
    output logic tick_o
);
    localparam int SW = $clog2(SEC_CYCLES + 1);
    localparam int MW = $clog2(MIN_UNITS + 1);

    logic [SW-1:0] sec_cnt_reg;
    logic [SW-1:0] sec_cnt_next;
    logic [MW-1:0] min_cnt_reg;
    logic [MW-1:0] min_cnt_next;
    logic tick_reg;
    logic tick_next;
    wire hold = restart_i | ~run_i;
    wire sec_done = sec_cnt_reg == SW'(SEC_CYCLES - 1);
    wire min_done = min_cnt_reg == MW'(MIN_UNITS - 1);

    // restart clears both stages so a reload gets a full first unit
    assign sec_cnt_next = (hold | sec_done) ? '0 : sec_cnt_reg + 1'b1;
    assign min_cnt_next = hold ? '0 :
        (sec_done ? (min_done ? '0 : min_cnt_reg + 1'b1) : min_cnt_reg);
    assign tick_next = ~hold & sec_done & (~minutes_i | min_done);
    assign tick_o = tick_reg;

    // prescaler state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sec_cnt_reg <= '0;
            min_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            sec_cnt_reg <= sec_cnt_next;
            min_cnt_reg <= min_cnt_next;
            tick_reg <= tick_next;
        end
    end
endmodule

// *** wdt_host_model.sv ***
// Purpose: host software model on the index/data port pair
// Assumes: one access per port_wr or port_rd call, strobes launched by NBA on CLK_I
// Notes: a released bus shows inverted data, never the last byte
`timescale 1ns/1ns
module wdt_host_model
    import wdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output wdt_pkg::io_req_type req_o
);
    // idle bus from time zero
    initial begin
        req_o = '0;
    end
    // one strobe cycle on a port, then release
    task automatic port_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, data: ~d};
    endtask
    // read strobe, answer awaited for a few cycles only
    task automatic port_rd(input logic [15:0] a, output logic [7:0] d,
                           output logic ok);
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: a, data: 8'hff};
        ok = 1'b0;
        d = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                ok = 1'b1;
            end else begin
                @(posedge clk_i);
            end
        end
    endtask
    // double key opens, single key closes
    task automatic unlock();
        port_wr(INDEX_PORT, UNLOCK_KEY);
        port_wr(INDEX_PORT, UNLOCK_KEY);
    endtask
    task automatic lock();
        port_wr(INDEX_PORT, LOCK_KEY);
    endtask
    // index first, then data
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
        port_wr(INDEX_PORT, idx);
        port_wr(DATA_PORT, v);
    endtask
    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d,
                          output logic ok);
        port_wr(INDEX_PORT, idx);
        port_rd(DATA_PORT, d, ok);
    endtask
endmodule

// *** wdt_pkg.sv ***
// Purpose: shared constants and types for the indexed-port watchdog
// Assumes: host port accesses arrive as one-cycle strobes on CLK_I
// Notes: all offsets, keys, field positions and reset values live here
package wdt_pkg;

    // host i/o port addresses
    localparam logic [15:0] INDEX_PORT = 16'h002e;
    localparam logic [15:0] DATA_PORT = 16'h002f;

    // keys written to the index port
    localparam logic [7:0] UNLOCK_KEY = 8'h87;
    localparam logic [7:0] LOCK_KEY = 8'haa;

    // register indexes
    localparam logic [7:0] REG_LDN = 8'h07;
    localparam logic [7:0] REG_ACT = 8'h30;
    localparam logic [7:0] REG_UNIT = 8'hf5;
    localparam logic [7:0] REG_COUNT = 8'hf6;
    localparam logic [7:0] REG_CTRL = 8'hf7;

    // logical device number of the watchdog set
    localparam logic [7:0] LDN_WDT = 8'h08;

    // field positions
    localparam int ACT_ON_BIT = 0;
    localparam int UNIT_MIN_BIT = 3;
    localparam int KBD_EN_BIT = 6;
    localparam int FORCE_BIT = 5;
    localparam int STATUS_BIT = 4;

    // reset values
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_LDN = 8'h00;
    localparam logic [7:0] RST_ACT = 8'h00;
    localparam logic [7:0] RST_UNIT = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] IDLE_READ = 8'h00;

    // timing: one second unit at the 125 MHz core clock
    localparam int CLK_PERIOD_NS = 8;
    localparam int UNIT_SEC_NS = 1000000000;
    localparam int SEC_CYCLES = UNIT_SEC_NS / CLK_PERIOD_NS;
    localparam int MIN_UNITS = 60;

    // one host port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } io_req_type;

    // configuration key sequencer
    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF = 2'b01,
        KEY_OPEN = 2'b10
    } key_state_type;

endpackage
